// ### hw/wdtu_top.sv
// Functional notes
// - Sixteen-bit timeout counter advances on the 32 kHz oscillator tick only.
// - With the arm bit clear, no reset and no interrupt come out.
// - Armed and not refreshed within the period: raise the chosen response.
// - Prescale n gives 2^n * 2^9 ticks; 8 resets at once; above reserved.
// - Response select one gives interrupt, zero gives system reset.
// - Watchdog interrupt ignores the core global interrupt mask.
// - Watchdog interrupt always carries fixed high priority.
// - In interrupt mode the counter restarts, forming a periodic timer.
// - Every timeout sets the timeout status flag.
// - Status clears by writing zero or hardware reset, survives watchdog reset.
// - Setting the arm bit enables the watchdog and clears its counter.
// - Arm bit clears on written zero, watchdog reset, or hardware reset.
// - Control writes outside the unlock window are ignored, except setting the unlock bit.
// - Control sits at C0H, bit addressable, powers up as 10H.
`timescale 1ns/1ps
module wdtu_top
	import wdtu_pkg::*;
#(
	parameter int TICK_DIV = WDTU_TICK_DIV
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_bit_addr_in,
	input wire logic sfr_bit_wr_in,
	input wire logic sfr_bit_val_in,
	input wire logic instr_end_in,
	output logic [7:0] sfr_rdata_out,
	output logic sys_reset_req_out,
	output logic wdt_irq_out,
	output logic wdt_irq_high_prio_out
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	generate
		if (TICK_DIV < 2) begin : g_bad_tick_div
			$error("wdtu_top: TICK_DIV must be at least 2");
		end
	endgenerate

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [3:0] pre_q;
	logic irsel_q;
	logic status_q;
	logic arm_q;
	wdtu_unlock_e unl_q;
	wdtu_unlock_e unl_d;
	logic [WDTU_CNT_W-1:0] cnt_q;
	logic tick_w;

	// ------------------------------------------------------------
	// Oscillator tick
	// ------------------------------------------------------------
	wdtu_tick #(
		.DIV(TICK_DIV)
	) u_tick (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.tick_out(tick_w)
	);

	// ------------------------------------------------------------
	// Register access decode
	// ------------------------------------------------------------
	logic [7:0] ctrl_rd_w;
	logic byte_hit_w;
	logic bit_hit_w;
	logic ctrl_hit_w;
	logic [7:0] wr_val_w;
	logic unlock_w;
	logic accept_w;
	logic [WDTU_BITSEL_W-1:0] bit_sel_w;

	assign ctrl_rd_w = {pre_q, irsel_q, status_q, arm_q, (unl_q != WDTU_LOCKED)};
	assign byte_hit_w = sfr_wr_in && (sfr_addr_in == WDTU_CTRL_ADDR);
	// Bit addresses C0..C7 map onto the eight control bits
	assign bit_hit_w = sfr_bit_wr_in &&
		(sfr_bit_addr_in[7:WDTU_BITSEL_W] == WDTU_CTRL_ADDR[7:WDTU_BITSEL_W]);
	assign bit_sel_w = sfr_bit_addr_in[WDTU_BITSEL_W-1:0];
	assign ctrl_hit_w = byte_hit_w || bit_hit_w;

	always_comb begin
		wr_val_w = ctrl_rd_w;
		if (byte_hit_w) begin
			wr_val_w = sfr_wdata_in;
		end else if (bit_hit_w) begin
			wr_val_w[bit_sel_w] = sfr_bit_val_in;
		end
	end

	// Setting the unlock bit is itself always allowed; it is what opens the window.
	// A bit write elsewhere must not renew it through the readback of bit 0.
	assign unlock_w = byte_hit_w ? sfr_wdata_in[WDTU_UNLOCK_BIT] :
		(bit_hit_w && (bit_sel_w == WDTU_BITSEL_W'(WDTU_UNLOCK_BIT)) && sfr_bit_val_in);
	assign accept_w = ctrl_hit_w && (unl_q == WDTU_OPEN);

	// ------------------------------------------------------------
	// Unlock window
	// ------------------------------------------------------------
	// The window opens at the end of the unlocking instruction and closes at
	// the end of the next one, so each accepted write needs its own unlock.
	always_comb begin
		unl_d = unl_q;
		case (unl_q)
			WDTU_LOCKED: begin
				if (unlock_w) begin
					unl_d = instr_end_in ? WDTU_OPEN : WDTU_PENDING;
				end
			end
			WDTU_PENDING: begin
				if (instr_end_in) begin
					unl_d = WDTU_OPEN;
				end
			end
			WDTU_OPEN: begin
				if (instr_end_in) begin
					unl_d = unlock_w ? WDTU_OPEN : WDTU_LOCKED;
				end else if (unlock_w) begin
					unl_d = WDTU_PENDING;
				end
			end
			default: begin
				unl_d = WDTU_LOCKED;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			unl_q <= WDTU_LOCKED;
		end else begin
			unl_q <= unl_d;
		end
	end

	// ------------------------------------------------------------
	// Timeout detection
	// ------------------------------------------------------------
	logic [16:0] span_w;
	logic [16:0] span_m1_w;
	logic [WDTU_CNT_W-1:0] lim_w;
	logic timed_w;
	logic immediate_w;
	logic timeout_w;
	logic wd_reset_w;
	logic wd_irq_w;

	assign span_w = WDTU_BASE_TICKS << pre_q[2:0];
	assign span_m1_w = span_w - 17'h00001;
	assign lim_w = span_m1_w[WDTU_CNT_W-1:0];
	assign timed_w = (pre_q <= WDTU_PRE_MAX_TIMED);
	assign immediate_w = arm_q && (pre_q == WDTU_PRE_IMMEDIATE);
	// Greater-or-equal so that shortening the prescale mid-period still fires
	assign timeout_w = immediate_w ||
		(arm_q && timed_w && tick_w && (cnt_q >= lim_w));
	assign wd_reset_w = timeout_w && (immediate_w || !irsel_q);
	assign wd_irq_w = timeout_w && !wd_reset_w;

	// ------------------------------------------------------------
	// Timeout counter
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= '0;
		end else if (wd_reset_w) begin
			cnt_q <= '0;
		end else if (accept_w && wr_val_w[WDTU_ARM_BIT]) begin
			cnt_q <= '0;
		end else if (!arm_q) begin
			cnt_q <= '0;
		end else if (tick_w) begin
			if (timeout_w) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + WDTU_CNT_W'(1);
			end
		end
	end

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pre_q <= WDTU_CTRL_RESET[WDTU_PRE_MSB:WDTU_PRE_LSB];
			irsel_q <= WDTU_CTRL_RESET[WDTU_IRSEL_BIT];
		end else if (accept_w) begin
			pre_q <= wr_val_w[WDTU_PRE_MSB:WDTU_PRE_LSB];
			irsel_q <= wr_val_w[WDTU_IRSEL_BIT];
		end
	end

	// A watchdog reset outranks a write landing in the same cycle
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arm_q <= WDTU_CTRL_RESET[WDTU_ARM_BIT];
		end else if (wd_reset_w) begin
			arm_q <= 1'b0;
		end else if (accept_w) begin
			arm_q <= wr_val_w[WDTU_ARM_BIT];
		end
	end

	// Only rstn_in clears the flag by hardware; the watchdog reset leaves it
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_q <= WDTU_CTRL_RESET[WDTU_STATUS_BIT];
		end else if (timeout_w) begin
			status_q <= 1'b1;
		end else if (accept_w && !wr_val_w[WDTU_STATUS_BIT]) begin
			status_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Responses and read data
	// ------------------------------------------------------------
	// No mask input exists on purpose: the interrupt cannot be held off
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sys_reset_req_out <= 1'b0;
			wdt_irq_out <= 1'b0;
			wdt_irq_high_prio_out <= 1'b1;
		end else begin
			sys_reset_req_out <= wd_reset_w;
			wdt_irq_out <= wd_irq_w;
			wdt_irq_high_prio_out <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sfr_rdata_out <= 8'h00;
		end else if (sfr_rd_in) begin
			sfr_rdata_out <= (sfr_addr_in == WDTU_CTRL_ADDR) ? ctrl_rd_w : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);

	chk_disabled_quiet: assert property (
		(sys_reset_req_out || wdt_irq_out) |-> $past(arm_q)
	) else $error("response raised while watchdog disarmed");

	chk_status_set: assert property (
		timeout_w |=> status_q
	) else $error("timeout did not set status flag");

	chk_irq_response: assert property (
		wd_irq_w |=> (wdt_irq_out && !sys_reset_req_out && cnt_q == '0)
	) else $error("interrupt response wrong");

	chk_reset_response: assert property (
		wd_reset_w |=> (sys_reset_req_out && !wdt_irq_out && !arm_q && cnt_q == '0)
	) else $error("reset response wrong");

	chk_locked_ignored: assert property (
		(ctrl_hit_w && !accept_w) |=> ($stable(pre_q) && $stable(irsel_q))
	) else $error("locked write changed control");

	chk_refresh_clear: assert property (
		(accept_w && wr_val_w[WDTU_ARM_BIT] && !wd_reset_w) |=> (arm_q && cnt_q == '0)
	) else $error("arm write did not restart counter");

	chk_window_once: assert property (
		(unl_q == WDTU_OPEN && instr_end_in && !unlock_w) |=> (unl_q == WDTU_LOCKED)
	) else $error("unlock window outlived one instruction");

	chk_tick_advance: assert property (
		(arm_q && tick_w && !timeout_w && !ctrl_hit_w) |=> (cnt_q == $past(cnt_q) + 16'h0001)
	) else $error("counter did not advance on tick");

	chk_no_tick_hold: assert property (
		(arm_q && !tick_w && !timeout_w && !ctrl_hit_w) |=> $stable(cnt_q)
	) else $error("counter moved without tick");

	chk_prio_fixed: assert property (
		wdt_irq_high_prio_out
	) else $error("interrupt priority not high");

	chk_status_keep: assert property (
		sys_reset_req_out |-> status_q
	) else $error("status lost on watchdog reset");

endmodule : wdtu_top

// ### hw/wdtu_pkg.sv
package wdtu_pkg;

	// ------------------------------------------------------------
	// Clock rates and tick divider
	// ------------------------------------------------------------
	localparam int WDTU_CORE_HZ = 25000000;
	localparam int WDTU_RC_HZ = 32000;
	// Integer division trims the oscillator tick about 0.03 % fast
	localparam int WDTU_TICK_DIV = WDTU_CORE_HZ / WDTU_RC_HZ;

	// ------------------------------------------------------------
	// Control register map
	// ------------------------------------------------------------
	localparam logic [7:0] WDTU_CTRL_ADDR = 8'hc0;
	localparam logic [7:0] WDTU_CTRL_RESET = 8'h10;
	localparam int WDTU_PRE_LSB = 4;
	localparam int WDTU_PRE_MSB = 7;
	localparam int WDTU_IRSEL_BIT = 3;
	localparam int WDTU_STATUS_BIT = 2;
	localparam int WDTU_ARM_BIT = 1;
	localparam int WDTU_UNLOCK_BIT = 0;
	localparam int WDTU_BITSEL_W = 3;

	// ------------------------------------------------------------
	// Prescale codes and period base
	// ------------------------------------------------------------
	localparam logic [3:0] WDTU_PRE_MAX_TIMED = 4'h7;
	localparam logic [3:0] WDTU_PRE_IMMEDIATE = 4'h8;
	localparam int WDTU_BASE_SHIFT = 9;
	localparam logic [16:0] WDTU_BASE_TICKS = 17'h00200;
	localparam int WDTU_CNT_W = 16;

	typedef enum logic [1:0] {
		WDTU_LOCKED,
		WDTU_PENDING,
		WDTU_OPEN
	} wdtu_unlock_e;

endpackage : wdtu_pkg

// ### hw/wdtu_tick.sv
`timescale 1ns/1ps
module wdtu_tick #(
	parameter int DIV = 781
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	output logic tick_out
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	generate
		if (DIV < 2) begin : g_bad_div
			$error("wdtu_tick: DIV must be at least 2");
		end
	endgenerate

	logic [CW-1:0] div_q;

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_q <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= (div_q == LAST);
			if (div_q == LAST) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + CW'(1);
			end
		end
	end

endmodule : wdtu_tick

// ### testbench/wdtu_core_model.sv
`timescale 1ns/1ps
module wdtu_core_model (
	input wire logic core_clk_in,
	input wire logic sys_reset_req_in,
	input wire logic wdt_irq_in,
	input wire logic wdt_irq_high_prio_in,
	output int irq_cnt_out,
	output int rst_cnt_out
);
	// ------------------------------------------------------------
	// Core side: the watchdog vector is taken with the mask set
	// ------------------------------------------------------------
	// No mask input on purpose: a masked core must still see it
	always_ff @(posedge core_clk_in) begin
		if (wdt_irq_in && wdt_irq_high_prio_in) irq_cnt_out <= irq_cnt_out + 1;
		if (sys_reset_req_in) rst_cnt_out <= rst_cnt_out + 1;
	end
endmodule : wdtu_core_model

// ### testbench/wdtu_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
	$display("FAIL %0t %s", $time, m); end end
module wdtu_top_bench;
	import wdtu_pkg::*;
	logic clk = 0;
	logic rstn = 0;
	logic [7:0] addr = 8'h00;
	logic wr = 0;
	logic [7:0] wdata = 8'h00;
	logic rd = 0;
	logic [7:0] baddr = 8'h00;
	logic bwr = 0;
	logic bval = 0;
	logic iend = 0;
	logic [7:0] rdata;
	logic rst_req;
	logic irq;
	logic prio;
	int irq_cnt;
	int rst_cnt;
	int fail_count = 0;
	int n_compared = 0;
	int n;

	wdtu_top #(.TICK_DIV(4)) wdtu_top_i (.core_clk_in(clk), .rstn_in(rstn),
		.sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rd_in(rd),
		.sfr_bit_addr_in(baddr), .sfr_bit_wr_in(bwr), .sfr_bit_val_in(bval),
		.instr_end_in(iend), .sfr_rdata_out(rdata), .sys_reset_req_out(rst_req),
		.wdt_irq_out(irq), .wdt_irq_high_prio_out(prio));
	wdtu_core_model wdtu_core_model_i (.core_clk_in(clk), .sys_reset_req_in(rst_req),
		.wdt_irq_in(irq), .wdt_irq_high_prio_in(prio), .irq_cnt_out(irq_cnt),
		.rst_cnt_out(rst_cnt));

	initial begin
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic ctl_wr(input logic [7:0] d, input logic unl);
		@(posedge clk);
		if (unl) begin
			baddr <= WDTU_CTRL_ADDR;
			bval <= 1'b1;
			bwr <= 1'b1;
			iend <= 1'b1;
			@(posedge clk);
			bwr <= 1'b0;
		end
		addr <= WDTU_CTRL_ADDR;
		wdata <= d;
		wr <= 1'b1;
		iend <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		iend <= 1'b0;
	endtask : ctl_wr

	task automatic bit_wr(input logic [2:0] b, input logic v);
		@(posedge clk);
		baddr <= WDTU_CTRL_ADDR | {5'h00, b};
		bval <= v;
		bwr <= 1'b1;
		iend <= 1'b1;
		@(posedge clk);
		bwr <= 1'b0;
		iend <= 1'b0;
	endtask : bit_wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, exp, m)
	endtask : rd_chk

	// Counts cycles until the chosen event count moves, capped by lim
	task automatic wait_evt(input logic use_irq, input int lim);
		int c0;
		c0 = use_irq ? irq_cnt : rst_cnt;
		n = 0;
		while ((use_irq ? irq_cnt : rst_cnt) == c0 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_evt

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	initial begin
		#1200000;
		fail_count++;
		finish_test();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(WDTU_CTRL_ADDR, 8'h10, "power-on value");
		rd_chk(8'hc1, 8'h00, "unmapped read");
		`CHK(prio, 1'b1, "priority not fixed high")
		ctl_wr(8'h0a, 1'b0);
		rd_chk(WDTU_CTRL_ADDR, 8'h10, "locked write taken");
		ctl_wr(8'h0a, 1'b1);
		rd_chk(WDTU_CTRL_ADDR, 8'h0a, "unlocked write lost");
		ctl_wr(8'h00, 1'b0);
		rd_chk(WDTU_CTRL_ADDR, 8'h0a, "write without fresh unlock");
		wait_evt(1'b1, 2200);
		`CHK(n inside {[2030:2070]}, 1'b1, "first period length")
		rd_chk(WDTU_CTRL_ADDR, 8'h0e, "status after interrupt");
		wait_evt(1'b1, 2200);
		`CHK(n inside {[2040:2056]}, 1'b1, "periodic interval")
		`CHK(rst_cnt, 0, "reset in interrupt mode")
		ctl_wr(8'h00, 1'b1);
		rd_chk(WDTU_CTRL_ADDR, 8'h00, "status not cleared");
		bit_wr(3'h0, 1'b1);
		bit_wr(3'h1, 1'b1);
		ctl_wr(8'h00, 1'b0);
		rd_chk(WDTU_CTRL_ADDR, 8'h02, "bit write left window open");
		ctl_wr(8'h00, 1'b1);
		wait_evt(1'b1, 3000);
		`CHK(n, 3000, "disarmed watchdog fired")
		`CHK(rst_cnt, 0, "disarmed watchdog reset")
		ctl_wr(8'h02, 1'b1);
		repeat (1500) @(posedge clk);
		ctl_wr(8'h02, 1'b1);
		wait_evt(1'b0, 2200);
		`CHK(n inside {[2030:2070]}, 1'b1, "reset mode period")
		`CHK(irq_cnt, 2, "interrupt in reset mode")
		rd_chk(WDTU_CTRL_ADDR, 8'h04, "after watchdog reset");
		ctl_wr(8'h82, 1'b1);
		wait_evt(1'b0, 10);
		`CHK(n < 10, 1'b1, "immediate reset missing")
		rd_chk(WDTU_CTRL_ADDR, 8'h84, "after immediate reset");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(WDTU_CTRL_ADDR, 8'h10, "hardware reset value");
		finish_test();
	end
endmodule : wdtu_top_bench
